// *** hdl/pcio_channel.sv ***
// Cable I/O channel: handshakes, function codes, interrupts, AHB-Lite regs
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps

module pcio_channel
    import pcio_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire pcio_pins_in_t pins_in,
    output pcio_pins_out_t pins_out
);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Read multiplexer; unmapped offsets answer zero
    function automatic logic [31:0] pcio_read(input pcio_regs_t s,
                                              input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            PCIO_OFF_CTRL: begin
                v[PCIO_CTRL_MCLR_BIT] = s.mclr;
                v[PCIO_CTRL_LOCK_BIT] = s.lockout;
            end
            PCIO_OFF_FN_UNIT: v[5:0] = s.fn_unit;
            PCIO_OFF_FN_FUNC: v[5:0] = s.fn_func;
            PCIO_OFF_OUT_DATA: v[7:0] = s.out_data;
            PCIO_OFF_IN_DATA: v[7:0] = s.in_data;
            PCIO_OFF_STATUS: v[9:0] = {s.mclr, s.lockout, s.pend,
                                       s.disc_flag, s.info_ready,
                                       s.fn_ready, s.request, s.st};
            PCIO_OFF_PC: v[11:0] = s.pc;
            PCIO_OFF_PSR: v[11:0] = s.program_save_register;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : pcio_read

    ////////////////////////////////////////////////////////////////////
    // State

    pcio_regs_t r_reg;
    pcio_regs_t r_next;
    logic [4:0] hs_pulse;
    logic ap_valid;

    // One pulse per assertion: arm only re-sets once the line is low
    assign hs_pulse = r_reg.hs_sync & r_reg.hs_arm;

    // Address phase qualifier for the single slave
    assign ap_valid = hsel & htrans[1] & hready;

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r_reg.hrdata;

    // All cable outputs straight from flip-flops
    assign pins_out.out_lines = r_reg.out_lines;
    assign pins_out.in_request = r_reg.request;
    assign pins_out.function_ready = r_reg.fn_ready;
    assign pins_out.info_ready = r_reg.info_ready;
    assign pins_out.master_clear = r_reg.mclr;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        r_next = r_reg;

        // Two-flop resync of every cable input before use
        r_next.hs_meta = {pins_in.int40, pins_in.int30, pins_in.out_resume,
                          pins_in.in_disconnect, pins_in.in_ready};
        r_next.hs_sync = r_reg.hs_meta;
        r_next.hs_arm = ~r_reg.hs_sync;
        r_next.d_meta = pins_in.lines;
        r_next.d_sync = r_reg.d_meta;

        // Bus address phase capture; read data prepared a cycle early
        r_next.dp_wr = ap_valid & hwrite;
        r_next.dp_addr = haddr[7:0];
        r_next.hrdata = 32'h0000_0000;
        if (ap_valid && !hwrite) begin
            r_next.hrdata = pcio_read(r_reg, haddr[7:0]);
        end

        // Data phase writes
        if (r_reg.dp_wr) begin
            case (r_reg.dp_addr)
                PCIO_OFF_CTRL: begin
                    r_next.mclr = hwdata[PCIO_CTRL_MCLR_BIT];
                    r_next.lockout = hwdata[PCIO_CTRL_LOCK_BIT];
                end
                // Two consecutive words build the 12-bit code
                PCIO_OFF_FN_UNIT: r_next.fn_unit = hwdata[5:0];
                PCIO_OFF_FN_FUNC: r_next.fn_func = hwdata[5:0];
                PCIO_OFF_OUT_DATA: r_next.out_data = hwdata[7:0];
                PCIO_OFF_PC: r_next.pc = hwdata[11:0];
                PCIO_OFF_CMD: begin
                    // Commands only start from idle; busy writes dropped
                    if (r_reg.st == PCIO_ST_IDLE && !r_reg.mclr) begin
                        case (hwdata[7:0])
                            PCIO_OP_INPUT, PCIO_OP_INPUT_ALT: begin
                                r_next.request = 1'b1;
                                r_next.disc_flag = 1'b0;
                                r_next.st = PCIO_ST_IN_WAIT;
                            end
                            PCIO_OP_OUTPUT: begin
                                // Data word in low bits of shared lines
                                r_next.out_lines = {4'h0,
                                                    r_reg.out_data};
                                r_next.info_ready = 1'b1;
                                r_next.st = PCIO_ST_OUT_WAIT;
                            end
                            PCIO_OP_FUNC: begin
                                r_next.out_lines = {r_reg.fn_unit,
                                                    r_reg.fn_func};
                                r_next.fn_ready = 1'b1;
                                r_next.st = PCIO_ST_FN_WAIT;
                            end
                            default: r_next.st = r_reg.st;
                        endcase
                    end
                end
                default: r_next.st = r_next.st;
            endcase
        end

        // Sequencer: each step waits for the equipment, no timer
        case (r_reg.st)
            PCIO_ST_IN_WAIT: begin
                if (hs_pulse[PCIO_HS_RDY]) begin
                    // Status replies arrive already OR'ed on the wire
                    r_next.in_data = r_reg.d_sync;
                    r_next.request = 1'b0;
                    r_next.st = PCIO_ST_IDLE;
                end else if (hs_pulse[PCIO_HS_DISC]) begin
                    r_next.request = 1'b0;
                    r_next.disc_flag = 1'b1;
                    r_next.st = PCIO_ST_IDLE;
                end
            end
            PCIO_ST_OUT_WAIT: begin
                // Lines untouched until resume, so they stay stable
                if (hs_pulse[PCIO_HS_RES]) begin
                    r_next.info_ready = 1'b0;
                    r_next.st = PCIO_ST_IDLE;
                end
            end
            PCIO_ST_FN_WAIT: begin
                if (hs_pulse[PCIO_HS_RES]) begin
                    r_next.fn_ready = 1'b0;
                    r_next.st = PCIO_ST_IDLE;
                end
            end
            default: r_next.st = r_next.st;
        endcase

        // Master clear abandons any handshake in flight
        if (r_reg.mclr) begin
            r_next.request = 1'b0;
            r_next.fn_ready = 1'b0;
            r_next.info_ready = 1'b0;
            r_next.st = PCIO_ST_IDLE;
        end

        // Interrupt lines latch; serviced when not locked, 30 first
        r_next.pend = r_next.pend | {hs_pulse[PCIO_HS_I40],
                                     hs_pulse[PCIO_HS_I30]};
        if (!r_reg.lockout) begin
            if (r_reg.pend[0]) begin
                r_next.program_save_register = r_reg.pc;
                r_next.pc = PCIO_VEC_INT30;
                r_next.pend[0] = hs_pulse[PCIO_HS_I30];
            end else if (r_reg.pend[1]) begin
                r_next.program_save_register = r_reg.pc;
                r_next.pc = PCIO_VEC_INT40;
                r_next.pend[1] = hs_pulse[PCIO_HS_I40];
            end
        end
    end

    // Single register of the whole state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= PCIO_REGS_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking pcio_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_req_drop_rdy: assert property (
        r_reg.st == PCIO_ST_IN_WAIT && hs_pulse[PCIO_HS_RDY] && !r_reg.mclr
        |=> !r_reg.request && r_reg.st == PCIO_ST_IDLE)
        else $error("input request not dropped on ready");

    a_in_sample_pulse: assert property (
        !(r_reg.st == PCIO_ST_IN_WAIT && hs_pulse[PCIO_HS_RDY])
        |=> $stable(r_reg.in_data))
        else $error("input word changed without ready pulse");

    a_disc_end_input: assert property (
        r_reg.st == PCIO_ST_IN_WAIT && hs_pulse[PCIO_HS_DISC]
        |=> r_reg.st == PCIO_ST_IDLE && !r_reg.request)
        else $error("disconnect did not end input");

    a_fn_ready_hold: assert property (
        r_reg.fn_ready && !hs_pulse[PCIO_HS_RES] && !r_reg.mclr
        |=> r_reg.fn_ready)
        else $error("function ready dropped early");

    a_fn_ready_drop: assert property (
        r_reg.st == PCIO_ST_FN_WAIT && hs_pulse[PCIO_HS_RES]
        |=> !r_reg.fn_ready)
        else $error("function ready kept after resume");

    a_info_ready_drop: assert property (
        r_reg.st == PCIO_ST_OUT_WAIT && hs_pulse[PCIO_HS_RES]
        |=> !r_reg.info_ready ##1 !r_reg.info_ready)
        else $error("information ready kept after resume");

    a_lines_stable: assert property (
        (r_reg.fn_ready || r_reg.info_ready) ##1
        (r_reg.fn_ready || r_reg.info_ready) |-> $stable(r_reg.out_lines))
        else $error("output lines moved under strobe");

    a_pulse_single: assert property (
        hs_pulse[PCIO_HS_RES] |=> !hs_pulse[PCIO_HS_RES])
        else $error("resume produced two pulses");

    a_vec_int30: assert property (
        r_reg.pend[0] && !r_reg.lockout
        |=> r_reg.pc == PCIO_VEC_INT30 && r_reg.program_save_register == $past(r_reg.pc))
        else $error("interrupt 30 vector not taken");

    a_vec_int40: assert property (
        !r_reg.pend[0] && r_reg.pend[1] && !r_reg.lockout
        |=> r_reg.pc == PCIO_VEC_INT40 && r_reg.program_save_register == $past(r_reg.pc))
        else $error("interrupt 40 vector not taken");

    a_fn_code_out: assert property (
        $rose(r_reg.fn_ready)
        |-> r_reg.out_lines == {$past(r_reg.fn_unit), $past(r_reg.fn_func)})
        else $error("function code fields misplaced");

    a_mclr_out: assert property (
        r_reg.dp_wr && r_reg.dp_addr == PCIO_OFF_CTRL
        && hwdata[PCIO_CTRL_MCLR_BIT] |=> pins_out.master_clear)
        else $error("master clear not driven");

    c_input_done: cover property (
        r_reg.st == PCIO_ST_IN_WAIT ##[1:200] r_reg.st == PCIO_ST_IDLE);
    c_func_done: cover property (
        $rose(r_reg.fn_ready) ##[1:200] $fell(r_reg.fn_ready));
    c_out_done: cover property (
        $rose(r_reg.info_ready) ##[1:200] $fell(r_reg.info_ready));
    c_int_taken: cover property (r_reg.pend[1] && !r_reg.lockout);

endmodule : pcio_channel

// *** hdl/pcio_pkg.sv ***
// Shared constants, types and register map of the cable I/O channel
package pcio_pkg;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] PCIO_OFF_CTRL = 8'h00;
    localparam logic [7:0] PCIO_OFF_CMD = 8'h04;
    localparam logic [7:0] PCIO_OFF_FN_UNIT = 8'h08;
    localparam logic [7:0] PCIO_OFF_FN_FUNC = 8'h0c;
    localparam logic [7:0] PCIO_OFF_OUT_DATA = 8'h10;
    localparam logic [7:0] PCIO_OFF_IN_DATA = 8'h14;
    localparam logic [7:0] PCIO_OFF_STATUS = 8'h18;
    localparam logic [7:0] PCIO_OFF_PC = 8'h1c;
    localparam logic [7:0] PCIO_OFF_PSR = 8'h20;

    // Control register fields
    localparam int PCIO_CTRL_MCLR_BIT = 0;
    localparam int PCIO_CTRL_LOCK_BIT = 1;

    // Instruction codes accepted by the command register (octal 72, 73, 75, 76)
    localparam logic [7:0] PCIO_OP_INPUT = 8'h3a;
    localparam logic [7:0] PCIO_OP_OUTPUT = 8'h3b;
    localparam logic [7:0] PCIO_OP_FUNC = 8'h3d;
    localparam logic [7:0] PCIO_OP_INPUT_ALT = 8'h3e;

    // Interrupt vectors, octal 0030 and 0040
    localparam logic [11:0] PCIO_VEC_INT30 = 12'h018;
    localparam logic [11:0] PCIO_VEC_INT40 = 12'h020;

    // Function code layout
    localparam int PCIO_FN_FIELD_W = 6;
    localparam int PCIO_WORD_W = 8;
    localparam int PCIO_OUT_W = 12;

    // Index of each asynchronous handshake line in the resync vector
    localparam int PCIO_HS_RDY = 0;
    localparam int PCIO_HS_DISC = 1;
    localparam int PCIO_HS_RES = 2;
    localparam int PCIO_HS_I30 = 3;
    localparam int PCIO_HS_I40 = 4;
    localparam int PCIO_HS_N = 5;

    typedef enum logic [1:0] {
        PCIO_ST_IDLE = 2'b00,
        PCIO_ST_IN_WAIT = 2'b01,
        PCIO_ST_OUT_WAIT = 2'b10,
        PCIO_ST_FN_WAIT = 2'b11
    } pcio_state_t;

    // Pins arriving on the input cable and interrupt lines
    typedef struct packed {
        logic [7:0] lines;
        logic in_ready;
        logic in_disconnect;
        logic out_resume;
        logic int30;
        logic int40;
    } pcio_pins_in_t;

    // Pins driven onto the cables
    typedef struct packed {
        logic [11:0] out_lines;
        logic in_request;
        logic function_ready;
        logic info_ready;
        logic master_clear;
    } pcio_pins_out_t;

    // Whole state of the channel
    typedef struct packed {
        pcio_state_t st;
        logic [4:0] hs_meta;
        logic [4:0] hs_sync;
        logic [4:0] hs_arm;
        logic [7:0] d_meta;
        logic [7:0] d_sync;
        logic [7:0] in_data;
        logic [7:0] out_data;
        logic [5:0] fn_unit;
        logic [5:0] fn_func;
        logic [11:0] out_lines;
        logic request;
        logic fn_ready;
        logic info_ready;
        logic mclr;
        logic lockout;
        logic disc_flag;
        logic [1:0] pend;
        logic [11:0] pc;
        logic [11:0] program_save_register;
        logic dp_wr;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
    } pcio_regs_t;

    localparam pcio_regs_t PCIO_REGS_RST = '0;

endpackage : pcio_pkg

// *** tb/pcio_equip_model.sv ***
// Behavioural model of the peripheral equipment on the cables
`timescale 1ns/1ps

module pcio_equip_model
    import pcio_pkg::*;
#(
    parameter logic [5:0] UNIT_ID = 6'h2b
)
(
    input wire logic hclk,
    input wire pcio_pins_out_t pins_out,
    input wire logic [7:0] word_a,
    input wire logic [7:0] word_b,
    input wire logic use_disc,
    input wire logic [7:0] delay,
    input wire logic irq30,
    input wire logic irq40,
    output pcio_pins_in_t pins_in,
    output logic [11:0] seen
);
    logic [7:0] lines = 8'h00;
    logic rdy = 1'b0;
    logic disc = 1'b0;
    logic res = 1'b0;

    // Interrupt lines pass through; data lines are a wired OR
    assign pins_in = '{lines, rdy, disc, res, irq30, irq40};
    initial seen = 12'h000;

    ////////////////////////////////////////////////////////////////////////
    // One transfer at a time, paced by this side
    always begin
        @(posedge hclk);
        if (pins_out.master_clear) begin
            rdy <= 1'b0;
            disc <= 1'b0;
            res <= 1'b0;
        end else if (pins_out.in_request) begin
            repeat (delay) @(posedge hclk);
            if (use_disc) begin
                disc <= 1'b1;
            end else begin
                lines <= word_a | word_b;
                // Settle two flops before the strobe
                repeat (3) @(posedge hclk);
                rdy <= 1'b1;
            end
            while (pins_out.in_request && !pins_out.master_clear) begin
                @(posedge hclk);
            end
            rdy <= 1'b0;
            disc <= 1'b0;
            // Released lines must not keep the word
            lines <= ~lines;
        end else if (pins_out.info_ready || (pins_out.function_ready &&
                     pins_out.out_lines[11:6] == UNIT_ID)) begin
            seen <= pins_out.out_lines;
            repeat (delay) @(posedge hclk);
            res <= 1'b1;
            while (pins_out.info_ready || pins_out.function_ready) begin
                @(posedge hclk);
            end
            res <= 1'b0;
        end
    end
endmodule : pcio_equip_model

// *** tb/testbench.sv ***
// Self-checking bench of the cable I/O channel
`timescale 1ns/1ps
`define CHECK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
    $display("mismatch %0t got %h exp %h", $time, (a), (b)); end end

module testbench
    import pcio_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp;
    logic [31:0] hrdata, rd;
    pcio_pins_in_t pins_in;
    pcio_pins_out_t pins_out;
    logic [7:0] word_a = 8'h00;
    logic [7:0] word_b = 8'h00;
    logic use_disc = 1'b0;
    logic [7:0] delay = 8'h02;
    logic irq30 = 1'b0;
    logic irq40 = 1'b0;
    logic [11:0] seen, prev_lines;
    logic prev_strobe = 1'b0;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;

    // 40 MHz clock
    always #12.5 hclk = ~hclk;

    pcio_channel pcio_channel_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pins_in(pins_in), .pins_out(pins_out));

    pcio_equip_model pcio_equip_model_inst (.hclk(hclk),
        .pins_out(pins_out), .word_a(word_a), .word_b(word_b),
        .use_disc(use_disc), .delay(delay), .irq30(irq30), .irq40(irq40),
        .pins_in(pins_in), .seen(seen));

    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    // One single AHB-Lite transfer, no assumed latency
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr

    task chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        `CHECK(rd, exp)
    endtask : chk

    // Poll until the channel is back to idle
    task wait_idle;
        int i;
        for (i = 0; i < 100; i++) begin
            ahb(1'b0, PCIO_OFF_STATUS, 32'h0);
            if (rd[1:0] === 2'b00) break;
        end
        `CHECK(rd[1:0], 2'b00)
        @(negedge hclk);
    endtask : wait_idle

    // Strobed output lines must hold still; hang guard
    always @(posedge hclk) begin
        if (prev_strobe && (pins_out.info_ready || pins_out.function_ready))
            `CHECK(pins_out.out_lines, prev_lines)
        prev_strobe = pins_out.info_ready || pins_out.function_ready;
        prev_lines = pins_out.out_lines;
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        `CHECK(pins_out, 16'h0000)
        chk(PCIO_OFF_STATUS, 32'h0);
        chk(8'h40, 32'h0);
        // Input word, then a slow one that must stall
        word_a <= 8'ha5;
        wr(PCIO_OFF_CMD, 32'h3a);
        @(negedge hclk);
        `CHECK(pins_out.in_request, 1'b1)
        wait_idle();
        `CHECK(pins_out.in_request, 1'b0)
        chk(PCIO_OFF_IN_DATA, 32'ha5);
        delay <= 8'h28;
        word_a <= 8'h5a;
        wr(PCIO_OFF_CMD, 32'h3e);
        repeat (20) @(posedge hclk);
        chk(PCIO_OFF_STATUS, 32'h5);
        chk(PCIO_OFF_IN_DATA, 32'ha5);
        wait_idle();
        chk(PCIO_OFF_IN_DATA, 32'h5a);
        // Two status codes at once (octal 064)
        delay <= 8'h02;
        word_a <= 8'h14;
        word_b <= 8'h20;
        wr(PCIO_OFF_CMD, 32'h3e);
        wait_idle();
        chk(PCIO_OFF_IN_DATA, 32'h34);
        use_disc <= 1'b1;
        wr(PCIO_OFF_CMD, 32'h3a);
        wait_idle();
        chk(PCIO_OFF_STATUS, 32'h20);
        use_disc <= 1'b0;
        // Function code for the attached unit
        wr(PCIO_OFF_FN_UNIT, 32'h2b);
        wr(PCIO_OFF_FN_FUNC, 32'h15);
        wr(PCIO_OFF_CMD, 32'h3d);
        @(negedge hclk);
        `CHECK(pins_out.out_lines, 12'had5)
        `CHECK(pins_out.function_ready, 1'b1)
        wait_idle();
        `CHECK(pins_out.function_ready, 1'b0)
        `CHECK(seen, 12'had5)
        // Code for an absent unit, aborted by master clear
        wr(PCIO_OFF_FN_UNIT, 32'h01);
        wr(PCIO_OFF_CMD, 32'h3d);
        repeat (30) @(posedge hclk);
        @(negedge hclk);
        `CHECK(pins_out.function_ready, 1'b1)
        wr(PCIO_OFF_CTRL, 32'h1);
        // Abort acts one edge after master clear is registered
        repeat (2) @(negedge hclk);
        `CHECK(pins_out.master_clear, 1'b1)
        `CHECK(pins_out.function_ready, 1'b0)
        wr(PCIO_OFF_CTRL, 32'h0);
        // Output word
        wr(PCIO_OFF_OUT_DATA, 32'hc3);
        wr(PCIO_OFF_CMD, 32'h3b);
        @(negedge hclk);
        `CHECK(pins_out.out_lines, 12'h0c3)
        `CHECK(pins_out.info_ready, 1'b1)
        wait_idle();
        `CHECK(pins_out.info_ready, 1'b0)
        `CHECK(seen, 12'h0c3)
        // Interrupts, one pulse per assertion, lockout
        wr(PCIO_OFF_PC, 32'h123);
        irq30 <= 1'b1;
        repeat (10) @(posedge hclk);
        chk(PCIO_OFF_PSR, 32'h123);
        chk(PCIO_OFF_PC, 32'h018);
        wr(PCIO_OFF_PC, 32'h777);
        repeat (10) @(posedge hclk);
        chk(PCIO_OFF_PC, 32'h777);
        irq30 <= 1'b0;
        wr(PCIO_OFF_PC, 32'h456);
        irq40 <= 1'b1;
        repeat (10) @(posedge hclk);
        irq40 <= 1'b0;
        chk(PCIO_OFF_PSR, 32'h456);
        chk(PCIO_OFF_PC, 32'h020);
        wr(PCIO_OFF_CTRL, 32'h2);
        wr(PCIO_OFF_PC, 32'h300);
        irq30 <= 1'b1;
        repeat (10) @(posedge hclk);
        irq30 <= 1'b0;
        chk(PCIO_OFF_PC, 32'h300);
        chk(PCIO_OFF_STATUS, 32'h160);
        wr(PCIO_OFF_CTRL, 32'h0);
        repeat (6) @(posedge hclk);
        chk(PCIO_OFF_PC, 32'h018);
        chk(PCIO_OFF_PSR, 32'h300);
        report_and_stop();
    end
endmodule : testbench
